// ==== rtl/urc_top.sv ====
/*
 UART receive core with 256-entry queue, behind an AHB-Lite slave.
 Assumes a single master; rx_serial and receive_bit_clock are asynchronous pins.
*/
// The implementer's own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module urc_top
    import urc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic rx_serial,
    input wire logic receive_bit_clock,
    output logic interrupt_request_n
);
    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic rx_s1_reg, rx_s_reg, rx_d_reg, bc_s1_reg, bc_s_reg, bc_d_reg;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_s1_reg <= 1'b1;
            rx_s_reg <= 1'b1;
            rx_d_reg <= 1'b1;
            bc_s1_reg <= 1'b0;
            bc_s_reg <= 1'b0;
            bc_d_reg <= 1'b0;
        end else begin
            rx_s1_reg <= rx_serial;
            rx_s_reg <= rx_s1_reg;
            rx_d_reg <= rx_s_reg;
            bc_s1_reg <= receive_bit_clock;
            bc_s_reg <= bc_s1_reg;
            bc_d_reg <= bc_s_reg;
        end
    end

    // ----------------------------------------------------------------
    // Registers, flags and queue state
    // ----------------------------------------------------------------
    logic [6:0] mode_reg, mode_next;
    logic [15:0] div_reg, div_next, dcnt_reg, dcnt_next;
    logic rx_en_reg, rx_en_next, ovr_reg, ovr_next, cob_reg, cob_next;
    logic wr_pend_reg, wr_pend_next, rd_pend_reg, rd_pend_next;
    logic [7:0] addr_reg, addr_next;
    logic hreadyout_reg, hreadyout_next, hresp_reg, irq_n_reg, irq_n_next;
    logic [31:0] hrdata_reg, hrdata_next;
    logic [Q_AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
    logic [8:0] q_cnt_reg, q_cnt_next;
    logic [Q_W-1:0] hold_reg, hold_next, q_wdata, head, entry;
    logic hold_valid_reg, hold_valid_next, q_we, pop, q_full, cmd_wr, err_rst, rx_rst, rx_dis;
    logic [Q_W-1:0] q_mem [0:255];
    // Receiver state
    urc_state_t state_reg, state_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [2:0] idx_reg, idx_next;
    logic [7:0] shift_reg, shift_next;
    logic zero_reg, zero_next, par_reg, par_next, hi_reg, hi_next;
    logic tick16, bclk_rise, sample_ev, start_ev, push_ev, brk, fe, pe;

    assign head = q_mem[rd_ptr_reg];
    assign q_full = (q_cnt_reg == Q_DEPTH);
    assign cmd_wr = wr_pend_reg && (addr_reg == OFS_CMD);
    assign err_rst = cmd_wr && hwdata[CMD_ERR];
    assign rx_rst = cmd_wr && hwdata[CMD_RST];
    assign rx_dis = cmd_wr && hwdata[CMD_DIS];
    // A divisor lowered mid-count must not leave the counter to run round
    assign tick16 = (dcnt_reg >= div_reg);
    assign bclk_rise = bc_s_reg && !bc_d_reg;

    function automatic logic [3:0] sample_point(input urc_state_t s);
        sample_point = (s == S_START || s == S_STOPX) ? HALF_CNT : FULL_CNT;
    endfunction

    // ----------------------------------------------------------------
    // Bit timing and receive state machine
    // ----------------------------------------------------------------
    always_comb begin
        sample_ev = mode_reg[MD_X1] ? bclk_rise : (tick16 && cnt_reg == sample_point(state_reg));
        dcnt_next = tick16 ? 16'h0000 : dcnt_reg + 16'h0001;
        state_next = state_reg;
        cnt_next = sample_ev ? 4'h0 : ((tick16 && !mode_reg[MD_X1]) ? cnt_reg + 4'h1 : cnt_reg);
        idx_next = idx_reg;
        shift_next = shift_reg;
        zero_next = zero_reg;
        par_next = par_reg;
        hi_next = hi_reg;
        start_ev = 1'b0;
        push_ev = 1'b0;
        brk = !zero_reg ? 1'b0 : (!par_reg && !rx_s_reg);
        fe = !rx_s_reg && !brk;
        pe = mode_reg[MD_PEN] && !brk && (par_reg != ((^shift_reg) ^ mode_reg[MD_PODD]));
        entry = {brk, fe, pe, shift_reg};
        case (state_reg)
            S_IDLE: begin
                dcnt_next = 16'h0000;
                cnt_next = 4'h0;
                if (rx_en_reg && rx_d_reg && !rx_s_reg) begin
                    state_next = S_START;
                end
            end
            S_START, S_STOPX: begin
                if (sample_ev) begin
                    if (rx_s_reg) begin
                        state_next = S_IDLE;
                    end else begin
                        state_next = S_DATA;
                        start_ev = 1'b1;
                        idx_next = 3'h0;
                        shift_next = 8'h00;
                        zero_next = 1'b1;
                        par_next = 1'b0;
                    end
                end
            end
            S_DATA: begin
                if (sample_ev) begin
                    shift_next[idx_reg] = rx_s_reg;
                    zero_next = zero_reg && !rx_s_reg;
                    idx_next = idx_reg + 3'h1;
                    if (idx_reg == {1'b0, mode_reg[MD_LEN_LO+1:MD_LEN_LO]} + 3'h4) begin
                        state_next = mode_reg[MD_PEN] ? S_PAR : S_STOP;
                    end
                end
            end
            S_PAR: begin
                if (sample_ev) begin
                    par_next = rx_s_reg;
                    state_next = S_STOP;
                end
            end
            S_STOP: begin
                if (sample_ev) begin
                    push_ev = 1'b1;
                    hi_next = 1'b0;
                    state_next = brk ? S_BREAK : (fe ? S_STOPX : S_IDLE);
                end
            end
            S_BREAK: begin
                if (sample_ev) begin
                    hi_next = rx_s_reg;
                    if (rx_s_reg && hi_reg) begin
                        state_next = S_IDLE;
                    end
                end
            end
            default: state_next = S_IDLE;
        endcase
        if (!rx_en_reg) begin
            state_next = S_IDLE;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= S_IDLE;
            dcnt_reg <= 16'h0000;
            cnt_reg <= 4'h0;
            idx_reg <= 3'h0;
            shift_reg <= 8'h00;
            zero_reg <= 1'b0;
            par_reg <= 1'b0;
            hi_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            dcnt_reg <= dcnt_next;
            cnt_reg <= cnt_next;
            idx_reg <= idx_next;
            shift_reg <= shift_next;
            zero_reg <= zero_next;
            par_reg <= par_next;
            hi_reg <= hi_next;
        end
    end

    // ----------------------------------------------------------------
    // Bus slave, queue and sticky flags
    // ----------------------------------------------------------------
    // Reads take one wait state so that read data leaves a flip-flop.
    always_comb begin
        wr_pend_next = hsel && htrans[1] && hready && hwrite;
        rd_pend_next = hsel && htrans[1] && hready && !hwrite;
        addr_next = (wr_pend_next || rd_pend_next) ? haddr[7:0] : addr_reg;
        hreadyout_next = !rd_pend_next;
        hrdata_next = hrdata_reg;
        mode_next = mode_reg;
        div_next = div_reg;
        rx_en_next = (rx_en_reg || (cmd_wr && hwdata[CMD_EN])) && !rx_dis && !rx_rst;
        pop = 1'b0;
        if (rd_pend_reg) begin
            hrdata_next = 32'h00000000;
            case (addr_reg)
                OFS_MODE: hrdata_next = {div_reg, 9'h000, mode_reg};
                OFS_STAT: begin
                    hrdata_next[ST_AVAIL] = (q_cnt_reg != 9'h000);
                    hrdata_next[ST_FULL] = q_full;
                    hrdata_next[ST_EN] = rx_en_reg;
                    hrdata_next[ST_OVR] = ovr_reg;
                    if (q_cnt_reg != 9'h000) begin
                        hrdata_next[ST_PE] = head[E_PE];
                        hrdata_next[ST_FE] = head[E_FE];
                        hrdata_next[ST_RB] = head[E_RB];
                    end
                end
                OFS_INT_STAT: begin
                    hrdata_next[IS_RDY] = (q_cnt_reg != 9'h000);
                    hrdata_next[IS_COB] = cob_reg;
                end
                OFS_DATA: begin
                    if (q_cnt_reg != 9'h000) begin
                        hrdata_next[7:0] = head[7:0];
                        pop = 1'b1;
                    end
                end
                default: hrdata_next = 32'h00000000;
            endcase
        end
        if (wr_pend_reg && addr_reg == OFS_MODE) begin
            mode_next = hwdata[6:0];
            div_next = hwdata[MD_DIV_LO+15:MD_DIV_LO];
        end
        // Set wins over clear for both sticky flags
        ovr_next = (ovr_reg && !err_rst && !rx_rst && !rx_dis) ||
                   (start_ev && q_full && hold_valid_reg);
        cob_next = (cob_reg && !err_rst && !rx_rst && !rx_dis) ||
                   (push_ev && brk) || (state_reg == S_BREAK && state_next == S_IDLE && rx_en_reg);
        // Queue write: held character first, one write per cycle
        q_we = 1'b0;
        q_wdata = entry;
        hold_next = hold_reg;
        hold_valid_next = hold_valid_reg;
        if (hold_valid_reg && !q_full) begin
            q_we = 1'b1;
            q_wdata = hold_reg;
            hold_valid_next = 1'b0;
        end
        if (push_ev) begin
            if (hold_valid_reg || q_full) begin
                hold_next = entry;
                hold_valid_next = 1'b1;
            end else begin
                q_we = 1'b1;
            end
        end
        wr_ptr_next = q_we ? wr_ptr_reg + 8'h01 : wr_ptr_reg;
        rd_ptr_next = pop ? rd_ptr_reg + 8'h01 : rd_ptr_reg;
        q_cnt_next = q_cnt_reg + {8'h00, q_we} - {8'h00, pop};
        if (rx_rst) begin
            wr_ptr_next = 8'h00;
            rd_ptr_next = 8'h00;
            q_cnt_next = 9'h000;
            hold_valid_next = 1'b0;
        end
        irq_n_next = !(rx_en_reg && (((q_cnt_reg != 9'h000) && mode_reg[MD_IE_RDY]) ||
                                     (cob_reg && mode_reg[MD_IE_BRK])));
    end

    always_ff @(posedge hclk) begin
        if (q_we) begin
            q_mem[wr_ptr_reg] <= q_wdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            addr_reg <= 8'h00;
            hreadyout_reg <= 1'b1;
            hrdata_reg <= 32'h00000000;
            hresp_reg <= 1'b0;
            mode_reg <= MODE_RST;
            div_reg <= DIV_RST;
            rx_en_reg <= 1'b0;
            ovr_reg <= 1'b0;
            cob_reg <= 1'b0;
            hold_reg <= 11'h000;
            hold_valid_reg <= 1'b0;
            wr_ptr_reg <= 8'h00;
            rd_ptr_reg <= 8'h00;
            q_cnt_reg <= 9'h000;
            irq_n_reg <= 1'b1;
        end else begin
            wr_pend_reg <= wr_pend_next;
            rd_pend_reg <= rd_pend_next;
            addr_reg <= addr_next;
            hreadyout_reg <= hreadyout_next;
            hrdata_reg <= hrdata_next;
            hresp_reg <= 1'b0;
            mode_reg <= mode_next;
            div_reg <= div_next;
            rx_en_reg <= rx_en_next;
            ovr_reg <= ovr_next;
            cob_reg <= cob_next;
            hold_reg <= hold_next;
            hold_valid_reg <= hold_valid_next;
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            q_cnt_reg <= q_cnt_next;
            irq_n_reg <= irq_n_next;
        end
    end

    assign hreadyout = hreadyout_reg;
    assign hrdata = hrdata_reg;
    assign hresp = hresp_reg;
    assign interrupt_request_n = irq_n_reg;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_fall;
        state_reg == S_IDLE && rx_en_reg && rx_d_reg && !rx_s_reg;
    endsequence
    sequence s_brk_hi;
        state_reg == S_BREAK && sample_ev && rx_s_reg && hi_reg && rx_en_reg;
    endsequence

    property p_start;
        s_fall |=> state_reg == S_START;
    endproperty
    a_start: assert property (p_start) else $error("start edge not taken");
    property p_abort;
        (state_reg == S_START && sample_ev && rx_s_reg) |=> state_reg == S_IDLE;
    endproperty
    a_abort: assert property (p_abort) else $error("false start not dropped");
    property p_push;
        (push_ev && !hold_valid_reg && !q_full && !pop && !rx_rst) |=> q_cnt_reg == $past(q_cnt_reg) + 9'h001;
    endproperty
    a_push: assert property (p_push) else $error("character not queued");
    property p_break;
        (push_ev && brk && rx_en_reg) |-> entry[7:0] == 8'h00 ##1 cob_reg;
    endproperty
    a_break: assert property (p_break) else $error("break not flagged");
    property p_brk_end;
        s_brk_hi |=> state_reg == S_IDLE && cob_reg;
    endproperty
    a_brk_end: assert property (p_brk_end) else $error("break end missed");
    property p_fe;
        (push_ev && !zero_reg && !rx_s_reg) |-> entry[E_FE] && !entry[E_RB];
    endproperty
    a_fe: assert property (p_fe) else $error("framing error missed");
    property p_ovr;
        (start_ev && q_full && hold_valid_reg) |=> ovr_reg;
    endproperty
    a_ovr: assert property (p_ovr) else $error("overrun not set");
    property p_ovr_keep;
        (ovr_reg && !err_rst && !rx_rst && !rx_dis) |=> ovr_reg;
    endproperty
    a_ovr_keep: assert property (p_ovr_keep) else $error("overrun lost");
    property p_irq_off;
        !rx_en_reg [*2] |-> interrupt_request_n;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("disabled receiver interrupts");
endmodule
`default_nettype wire

// ==== rtl/urc_pkg.sv ====
/*
 Constants, register map and state type for the UART receive core.
 Assumes a 32-bit AHB-Lite slave with word-aligned registers.
*/
package urc_pkg;
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_MODE = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam logic [7:0] OFS_INT_STAT = 8'h0c;
    localparam logic [7:0] OFS_DATA = 8'h10;
    // Command bits (write one to act)
    localparam int CMD_EN = 0;
    localparam int CMD_DIS = 1;
    localparam int CMD_RST = 2;
    localparam int CMD_ERR = 3;
    // Mode fields
    localparam int MD_LEN_LO = 0;
    localparam int MD_PEN = 2;
    localparam int MD_PODD = 3;
    localparam int MD_X1 = 4;
    localparam int MD_IE_RDY = 5;
    localparam int MD_IE_BRK = 6;
    localparam int MD_DIV_LO = 16;
    localparam logic [15:0] DIV_RST = 16'h0081;
    localparam logic [6:0] MODE_RST = 7'h03;
    // Status fields
    localparam int ST_AVAIL = 0;
    localparam int ST_FULL = 1;
    localparam int ST_EN = 2;
    localparam int ST_OVR = 4;
    localparam int ST_PE = 5;
    localparam int ST_FE = 6;
    localparam int ST_RB = 7;
    localparam int IS_RDY = 1;
    localparam int IS_COB = 2;
    // Queue entry: {break, framing, parity, data}
    localparam int Q_W = 11;
    localparam int Q_AW = 8;
    localparam logic [8:0] Q_DEPTH = 9'h100;
    localparam int E_PE = 8;
    localparam int E_FE = 9;
    localparam int E_RB = 10;
    // Sample points in 16x ticks
    localparam logic [3:0] HALF_CNT = 4'h7;
    localparam logic [3:0] FULL_CNT = 4'hf;
    typedef enum logic [2:0] {
        S_IDLE, S_START, S_DATA, S_PAR, S_STOP, S_STOPX, S_BREAK
    } urc_state_t;
endpackage

// ==== testbench/urc_line_model.sv ====
/*
 Far-side model: an asynchronous transmitter that drives the serial line
 and, in 1x mode, the bit clock.
 Assumes hclk as time base; one bit lasts BIT hclk cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module urc_line_model #(
    parameter int BIT = 16
) (
    input wire logic hclk,
    output logic rx_serial,
    output logic receive_bit_clock
);
    initial begin
        rx_serial = 1'b1;
        receive_bit_clock = 1'b0;
    end
    // Holds a raw level; the bit clock stands still meanwhile
    task automatic hold(input logic v, input int n);
        rx_serial <= v;
        repeat (n) @(posedge hclk);
    endtask
    // Bit clock rises mid-bit, and only inside frames
    task automatic put_bit(input logic v, input logic x1);
        rx_serial <= v;
        repeat (BIT / 2) @(posedge hclk);
        if (x1) begin
            receive_bit_clock <= 1'b1;
        end
        repeat (BIT / 2) @(posedge hclk);
        receive_bit_clock <= 1'b0;
    endtask
    task automatic send(input logic [7:0] d, input int nb, input logic pen, input logic podd,
                        input logic perr, input logic ferr, input logic x1);
        logic p;
        p = podd ^ perr;
        put_bit(1'b0, x1);
        for (int i = 0; i < nb; i++) begin
            p = p ^ d[i];
            put_bit(d[i], x1);
        end
        if (pen) begin
            put_bit(p, x1);
        end
        // A bad stop is released early so it cannot pass for a new start
        if (ferr) begin
            hold(1'b0, BIT * 3 / 4);
            hold(1'b1, BIT / 4);
        end else begin
            put_bit(1'b1, x1);
        end
    endtask
endmodule
`default_nettype wire

// ==== testbench/uart_receiver_core_bench.sv ====
/*
 Self-checking bench for the receive core: AHB-Lite master tasks,
 random and corner-case characters through the line model.
 Assumes divisor 0, so one bit is 16 hclk cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module uart_receiver_core_bench;
    import urc_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic interrupt_request_n;
    logic rx_serial;
    logic receive_bit_clock;
    logic [31:0] hrdata;
    int error_cnt = 0;
    int n_checks = 0;
    logic [7:0] sent[$];

    always #25 hclk = ~hclk;

    urc_top u_urc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .rx_serial(rx_serial), .receive_bit_clock(receive_bit_clock),
        .interrupt_request_n(interrupt_request_n));
    urc_line_model #(.BIT(16)) u_urc_line_model (.hclk(hclk), .rx_serial(rx_serial),
        .receive_bit_clock(receive_bit_clock));

    // ----------------------------------------------------------------
    // Reporting
    // ----------------------------------------------------------------
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // ----------------------------------------------------------------
    // Bus master
    // ----------------------------------------------------------------
    task automatic wait_ready;
        int k;
        k = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            k++;
            if (k > 100) begin
                error_cnt++;
                $display("ERROR bus wait expected ready seen timeout");
                print_verdict();
            end
            @(posedge hclk);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
        chk("hresp", hresp, 32'h0);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask
    task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        chk(what, x, exp);
    endtask

    function automatic logic [31:0] mode_val(input logic [1:0] len, input logic pen, input logic podd,
                                             input logic x1, input logic ie_r, input logic ie_b);
        return {25'h0, ie_b, ie_r, x1, podd, pen, len};
    endfunction
    function automatic logic [7:0] mask(input logic [7:0] d, input int nb);
        return d & 8'((1 << nb) - 1);
    endfunction

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [7:0] d;
        logic [1:0] c;
        int kind;
        logic pen;
        logic podd;
        void'($urandom(60));
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk("hreadyout", hreadyout, 32'h1);
        chk("irq", interrupt_request_n, 32'h1);
        rdc("mode", OFS_MODE, 32'h0081_0003);
        wr(8'h20, 32'hffff_ffff);
        rdc("unmapped", 8'h20, 32'h0);
        wr(OFS_STAT, 32'hff);
        rdc("stat", OFS_STAT, 32'h0);
        wr(OFS_CMD, 32'h1);
        rdc("stat", OFS_STAT, 32'h4);
        $display("test reset done");
        // Random length and parity modes, with parity and framing faults
        for (int i = 0; i < 15; i++) begin
            c = 2'($urandom_range(3));
            kind = i % 3;
            pen = (kind == 1) | 1'($urandom_range(1));
            podd = 1'($urandom_range(1));
            d = 8'($urandom) | ((kind == 2) ? 8'h1 : 8'h0);
            wr(OFS_MODE, mode_val(c, pen, podd, 0, 0, 0));
            u_urc_line_model.send(d, c + 5, pen, podd, kind == 1, kind == 2, 1'b0);
            rdc("stat", OFS_STAT, 32'h5 | (kind == 1 ? 32'h20 : 0) | (kind == 2 ? 32'h40 : 0));
            rdc("int_stat", OFS_INT_STAT, 32'h2);
            rdc("data", OFS_DATA, {24'h0, mask(d, c + 5)});
            rdc("stat", OFS_STAT, 32'h4);
        end
        $display("test characters done");
        wr(OFS_MODE, mode_val(2'h3, 0, 0, 0, 1, 0));
        u_urc_line_model.hold(1'b0, 4);
        u_urc_line_model.hold(1'b1, 16);
        u_urc_line_model.send(8'ha5, 8, 0, 0, 0, 0, 0);
        chk("irq", interrupt_request_n, 32'h0);
        rdc("data", OFS_DATA, 32'ha5);
        rdc("stat", OFS_STAT, 32'h4);
        u_urc_line_model.send(8'h3c, 8, 0, 0, 0, 0, 0);
        wr(OFS_CMD, 32'h2);
        rdc("stat", OFS_STAT, 32'h1);
        chk("irq", interrupt_request_n, 32'h1);
        u_urc_line_model.send(8'h77, 8, 0, 0, 0, 0, 0);
        rdc("stat", OFS_STAT, 32'h1);
        wr(OFS_CMD, 32'h1);
        wr(OFS_CMD, 32'h4);
        rdc("stat", OFS_STAT, 32'h0);
        wr(OFS_CMD, 32'h1);
        wr(OFS_MODE, mode_val(2'h3, 0, 0, 1, 0, 0));
        u_urc_line_model.send(8'h96, 8, 0, 0, 0, 0, 1);
        rdc("data", OFS_DATA, 32'h96);
        $display("test gating done");
        // Break start and end
        wr(OFS_MODE, mode_val(2'h3, 0, 0, 0, 0, 1));
        u_urc_line_model.hold(1'b0, 176);
        rdc("stat", OFS_STAT, 32'h85);
        rdc("int_stat", OFS_INT_STAT, 32'h6);
        chk("irq", interrupt_request_n, 32'h0);
        wr(OFS_CMD, 32'h8);
        rdc("int_stat", OFS_INT_STAT, 32'h2);
        u_urc_line_model.hold(1'b1, 48);
        rdc("int_stat", OFS_INT_STAT, 32'h6);
        rdc("data", OFS_DATA, 32'h0);
        wr(OFS_CMD, 32'h8);
        rdc("stat", OFS_STAT, 32'h4);
        // Bad stop with the line kept low: a new start counts from the stop centre
        d = 8'($urandom);
        u_urc_line_model.hold(1'b0, 16);
        u_urc_line_model.hold(1'b1, 16);
        u_urc_line_model.hold(1'b0, 136);
        for (int i = 0; i < 8; i++) begin
            u_urc_line_model.hold(d[i], 16);
        end
        u_urc_line_model.hold(1'b1, 32);
        rdc("stat", OFS_STAT, 32'h45);
        rdc("data", OFS_DATA, 32'h01);
        rdc("data", OFS_DATA, {24'h0, d});
        $display("test break done");
        // Queue plus hold register fill, then one overrunning character
        wr(OFS_MODE, mode_val(2'h3, 0, 0, 0, 0, 0));
        for (int k = 0; k < 258; k++) begin
            d = 8'($urandom);
            sent.push_back(d);
            u_urc_line_model.send(d, 8, 0, 0, 0, 0, 0);
        end
        rdc("stat", OFS_STAT, 32'h17);
        for (int k = 0; k < 257; k++) begin
            rdc("data", OFS_DATA, {24'h0, sent[(k < 256) ? k : 257]});
        end
        rdc("stat", OFS_STAT, 32'h14);
        wr(OFS_CMD, 32'h8);
        rdc("stat", OFS_STAT, 32'h4);
        $display("test overrun done");
        print_verdict();
    end
endmodule
`default_nettype wire
